// File: vcd_consts.vh
// What this block does
// - First calibration after reset starts when an update write applies a set calibration start bit.
// - Status bit 6 reads one once the oscillator calibration has completed.
// - Calibration sequencer is paced by the divided reference input clock.
// - Outputs held static by internal sync while calibration runs, released afterwards.
// - Calibration clock is reference divided by R, then by two-bit divider field.
// - Calibration lasts 4400 calibration clocks, that is 4400 times R times divider.
// - Calibration never starts by itself when loop dividers change.
// - Five channels; three single dividers divide by 2 to 32 or bypass.
// - Two dual channels cascade two dividers; ratio is the product, up to 1024.
// - Output high for high count plus one, low for low count plus one.
// - Duty fix can be disabled; corrects odd ratio only when low equals high plus one.
// - Coarse delay in whole input cycles up to 31, selectable start level.
// - Prescaler divides by 2 to 6; needed for oscillator or fast external input.
// - Source field: 00 external prescaled, 01 external direct, 10 oscillator, 11 none.
// - Prescaler input may route direct to outputs only with prescaled source selected.
`ifndef VCD_CONSTS_VH
`define VCD_CONSTS_VH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define VCD_IDX_CAL 10'h018
`define VCD_IDX_STATUS 10'h01f
`define VCD_IDX_SRC 10'h1e1
`define VCD_IDX_UPDATE 10'h232
`define VCD_IDX_RDIV 10'h011
`define VCD_IDX_PRESCALE 10'h1e0
`define VCD_IDX_CH0 10'h190

// ----------------------------------------
// Internal register slots
// ----------------------------------------
`define VCD_ID_CAL 4'h0
`define VCD_ID_STATUS 4'h1
`define VCD_ID_SRC 4'h2
`define VCD_ID_UPDATE 4'h3
`define VCD_ID_RDIV 4'h4
`define VCD_ID_PRESCALE 4'h5
`define VCD_ID_CH0 4'h6
`define VCD_ID_NONE 4'hf
`define VCD_NUM_REGS 11

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define VCD_CAL_START_BIT 0
`define VCD_CAL_DIV_LSB 1
`define VCD_STATUS_DONE_BIT 6
`define VCD_UPDATE_BIT 0
`define VCD_MASK_BYTE 32'h0000_00ff
`define VCD_MASK_SRC 32'h0000_0003
`define VCD_MASK_RDIV 32'h0000_3fff
`define VCD_MASK_PRESCALE 32'h0000_0007
`define VCD_MASK_CH 32'h3fff_ffff
`define VCD_CH_HIGH_LSB 0
`define VCD_CH_LOW_LSB 4
`define VCD_CH_BYPASS_BIT 8
`define VCD_CH_DUTY_OFF_BIT 9
`define VCD_CH_DELAY_LSB 10
`define VCD_CH_START_BIT 15
`define VCD_CH_HIGH2_LSB 20
`define VCD_CH_LOW2_LSB 24
`define VCD_CH_BYPASS2_BIT 28
`define VCD_CH_DIRECT_BIT 29

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define VCD_RST_CAL 32'h0000_0000
`define VCD_RST_SRC 32'h0000_0000
`define VCD_RST_RDIV 32'h0000_0001
`define VCD_RST_PRESCALE 32'h0000_0002
`define VCD_RST_CH 32'h0000_0000
`define VCD_CAL_CLOCKS 4400
`define VCD_RESP_OKAY 2'b00
`define VCD_RESP_SLVERR 2'b10

`endif

// File: vcd_prescale.v
`include "vcd_consts.vh"

module vcd_prescale (
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire clk_en, // Freezes state when low
	input wire [2:0] ratio, // Divide ratio 2 to 6
	input wire in_rise, // Rising edge of source
	output reg out_level, // Divided clock level
	output reg out_rise, // One-cycle rising edge pulse
	output reg out_fall // One-cycle falling edge pulse
);
	reg [2:0] cnt;
	reg [2:0] r;
	reg [2:0] next_cnt;
	reg next_level;

	always @* begin
		// Out-of-range ratios clamp into 2..6
		r = (ratio < 3'd2) ? 3'd2 : ((ratio > 3'd6) ? 3'd6 : ratio);
		next_cnt = cnt;
		next_level = out_level;
		if (in_rise) begin
			next_cnt = (cnt >= r - 3'd1) ? 3'd0 : cnt + 3'd1;
			next_level = (next_cnt < ((r + 3'd1) >> 1));
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 3'd0;
			out_level <= 1'b0;
			out_rise <= 1'b0;
			out_fall <= 1'b0;
		end else if (clk_en) begin
			cnt <= next_cnt;
			out_level <= next_level;
			out_rise <= next_level & ~out_level;
			out_fall <= ~next_level & out_level;
		end
	end
endmodule // vcd_prescale

// File: vcd_chdiv.v
`include "vcd_consts.vh"

module vcd_chdiv (
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire clk_en, // Freezes state when low
	input wire hold, // Sync hold: output static
	input wire in_level, // Divider input level
	input wire in_rise, // Input rising edge pulse
	input wire in_fall, // Input falling edge pulse
	input wire [3:0] high_cnt, // High cycles minus one
	input wire [3:0] low_cnt, // Low cycles minus one
	input wire bypass, // Pass input straight through
	input wire duty_fix_disable, // Turns duty correction off
	input wire [4:0] delay, // Coarse delay in input cycles
	input wire start_high, // Level of the first phase
	output reg out_level, // Divided output level
	output reg out_rise, // Output rising edge pulse
	output reg out_fall // Output falling edge pulse
);
	reg [3:0] cnt;
	reg [4:0] dly;
	reg wait_fall;
	reg next_level;
	wire odd_fix;

	// Widened compare so a high count of 15 cannot wrap onto a low count of 0
	assign odd_fix = ~duty_fix_disable & ({1'b0, low_cnt} == {1'b0, high_cnt} + 5'd1);

	always @* begin
		next_level = out_level;
		if (hold)
			next_level = start_high;
		else if (bypass)
			next_level = in_level;
		else if (wait_fall && in_fall)
			next_level = 1'b0;
		else if (!wait_fall && in_rise && dly == 5'd0) begin
			if (out_level && cnt == high_cnt && !odd_fix)
				next_level = 1'b0;
			else if (!out_level && cnt == low_cnt)
				next_level = 1'b1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 4'd0;
			dly <= 5'd0;
			wait_fall <= 1'b0;
			out_level <= 1'b0;
			out_rise <= 1'b0;
			out_fall <= 1'b0;
		end else if (clk_en) begin
			out_level <= next_level;
			out_rise <= next_level & ~out_level;
			out_fall <= ~next_level & out_level;
			if (hold) begin
				cnt <= 4'd0;
				dly <= delay;
				wait_fall <= 1'b0;
			end else if (wait_fall) begin
				// Odd ratio: high phase stretched by half an input cycle
				if (in_fall) begin
					wait_fall <= 1'b0;
					cnt <= 4'd0;
				end
			end else if (in_rise && !bypass) begin
				if (dly != 5'd0)
					dly <= dly - 5'd1;
				else if (out_level && cnt == high_cnt) begin
					cnt <= 4'd0;
					wait_fall <= odd_fix;
				end else if (!out_level && cnt == low_cnt)
					cnt <= 4'd0;
				else
					cnt <= cnt + 4'd1;
			end
		end
	end
endmodule // vcd_chdiv

// File: vcd_top.v
`include "vcd_consts.vh"

module vcd_top #(
	parameter CAL_CLOCKS = `VCD_CAL_CLOCKS // Calibration length in calibration clocks
) (
	input wire aclk, // System clock, 40 MHz
	input wire aresetn, // Synchronous reset, active low
	input wire clk_en, // Freezes all state when low
	input wire [11:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write byte strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [11:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire reference_input_clock, // Reference clock pin
	input wire ext_clock_in, // External clock input pin
	input wire osc_clock_in, // Internal oscillator clock
	output reg ch0_out, // Single-divider channel 0
	output reg ch1_out, // Single-divider channel 1
	output reg ch2_out, // Single-divider channel 2
	output reg ch3_out, // Dual-divider channel 3
	output reg ch4_out, // Dual-divider channel 4
	output reg cal_sync_hold // High while calibration holds outputs
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;
	localparam integer CAL_LAST_I = CAL_CLOCKS - 1;
	localparam [12:0] CAL_LAST = CAL_LAST_I[12:0];

	// ----------------------------------------
	// Address decode and write masks
	// ----------------------------------------
	function [3:0] decode;
		input [9:0] idx;
		begin
			case (idx)
				`VCD_IDX_CAL: decode = `VCD_ID_CAL;
				`VCD_IDX_STATUS: decode = `VCD_ID_STATUS;
				`VCD_IDX_SRC: decode = `VCD_ID_SRC;
				`VCD_IDX_UPDATE: decode = `VCD_ID_UPDATE;
				`VCD_IDX_RDIV: decode = `VCD_ID_RDIV;
				`VCD_IDX_PRESCALE: decode = `VCD_ID_PRESCALE;
				default: begin
					if (idx >= `VCD_IDX_CH0 && idx <= `VCD_IDX_CH0 + 10'd4)
						decode = `VCD_ID_CH0 + idx[3:0];
					else
						decode = `VCD_ID_NONE;
				end
			endcase
		end
	endfunction

	function [31:0] wmask;
		input [3:0] id;
		begin
			case (id)
				`VCD_ID_CAL: wmask = `VCD_MASK_BYTE;
				`VCD_ID_SRC: wmask = `VCD_MASK_SRC;
				`VCD_ID_RDIV: wmask = `VCD_MASK_RDIV;
				`VCD_ID_PRESCALE: wmask = `VCD_MASK_PRESCALE;
				default: wmask = `VCD_MASK_CH;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [2:0] ref_sync;
	reg [2:0] ext_sync;
	reg [2:0] osc_sync;
	wire ref_rise = ref_sync[1] & ~ref_sync[2];
	wire ext_rise = ext_sync[1] & ~ext_sync[2];
	wire ext_fall = ~ext_sync[1] & ext_sync[2];
	wire osc_rise = osc_sync[1] & ~osc_sync[2];

	always @(posedge aclk) begin
		if (!aresetn) begin
			ref_sync <= 3'd0;
			ext_sync <= 3'd0;
			osc_sync <= 3'd0;
		end else if (clk_en) begin
			ref_sync <= {ref_sync[1:0], reference_input_clock};
			ext_sync <= {ext_sync[1:0], ext_clock_in};
			osc_sync <= {osc_sync[1:0], osc_clock_in};
		end
	end

	// ----------------------------------------
	// Register file: shadow and active copies
	// ----------------------------------------
	reg [31:0] shadow [0:`VCD_NUM_REGS-1];
	reg [31:0] active [0:`VCD_NUM_REGS-1];
	reg aw_held;
	reg w_held;
	reg [9:0] aw_idx;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg update_pulse;
	reg cal_done;
	reg [1:0] cal_state;
	reg [31:0] rd_val;
	reg [31:0] bytemask;
	wire [3:0] wr_id = decode(aw_idx);
	wire [3:0] rd_id = decode(s_axi_araddr[11:2]);
	wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
	integer i;

	always @* begin
		bytemask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
		if (rd_id == `VCD_ID_STATUS)
			rd_val = {25'd0, cal_done, 6'd0};
		else if (rd_id == `VCD_ID_UPDATE || rd_id == `VCD_ID_NONE)
			rd_val = 32'h0000_0000;
		else
			rd_val = shadow[rd_id];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `VCD_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `VCD_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 10'd0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			update_pulse <= 1'b0;
			for (i = 0; i < `VCD_NUM_REGS; i = i + 1) begin
				shadow[i] <= `VCD_RST_CH;
				active[i] <= `VCD_RST_CH;
			end
			shadow[`VCD_ID_RDIV] <= `VCD_RST_RDIV;
			active[`VCD_ID_RDIV] <= `VCD_RST_RDIV;
			shadow[`VCD_ID_PRESCALE] <= `VCD_RST_PRESCALE;
			active[`VCD_ID_PRESCALE] <= `VCD_RST_PRESCALE;
		end else if (clk_en) begin
			update_pulse <= 1'b0;
			s_axi_awready <= ~aw_held & s_axi_awvalid & ~s_axi_awready;
			s_axi_wready <= ~w_held & s_axi_wvalid & ~s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_idx <= s_axi_awaddr[11:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_id == `VCD_ID_NONE) ? `VCD_RESP_SLVERR : `VCD_RESP_OKAY;
				if (wr_id == `VCD_ID_UPDATE)
					update_pulse <= w_strb[0] & w_data[`VCD_UPDATE_BIT];
				else if (wr_id != `VCD_ID_NONE && wr_id != `VCD_ID_STATUS)
					shadow[wr_id] <= (shadow[wr_id] & ~bytemask)
						| (w_data & bytemask & wmask(wr_id));
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (update_pulse) begin
				for (i = 0; i < `VCD_NUM_REGS; i = i + 1)
					active[i] <= shadow[i];
			end
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= (rd_id == `VCD_ID_NONE) ? `VCD_RESP_SLVERR : `VCD_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Calibration sequencer
	// ----------------------------------------
	// Starts only on a 0-to-1 edge of the applied start bit, never on divider edits
	wire cal_req = update_pulse & shadow[`VCD_ID_CAL][`VCD_CAL_START_BIT]
		& ~active[`VCD_ID_CAL][`VCD_CAL_START_BIT];
	wire [13:0] r_val = active[`VCD_ID_RDIV][13:0];
	wire [13:0] r_last = (r_val == 14'd0) ? 14'd0 : r_val - 14'd1;
	wire [1:0] div_sel = active[`VCD_ID_CAL][`VCD_CAL_DIV_LSB+1:`VCD_CAL_DIV_LSB];
	wire [3:0] div_last = (4'd2 << div_sel) - 4'd1;
	reg [13:0] r_cnt;
	reg [3:0] d_cnt;
	reg [12:0] cal_cnt;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cal_state <= ST_IDLE;
			cal_done <= 1'b0;
			cal_sync_hold <= 1'b0;
			r_cnt <= 14'd0;
			d_cnt <= 4'd0;
			cal_cnt <= 13'd0;
		end else if (clk_en) begin
			case (cal_state)
				ST_IDLE: begin
					if (cal_req) begin
						cal_state <= ST_RUN;
						cal_done <= 1'b0;
						cal_sync_hold <= 1'b1;
						r_cnt <= 14'd0;
						d_cnt <= 4'd0;
						cal_cnt <= 13'd0;
					end
				end
				ST_RUN: begin
					if (cal_req) begin
						r_cnt <= 14'd0;
						d_cnt <= 4'd0;
						cal_cnt <= 13'd0;
					end else if (ref_rise) begin
						r_cnt <= (r_cnt == r_last) ? 14'd0 : r_cnt + 14'd1;
						if (r_cnt == r_last) begin
							d_cnt <= (d_cnt == div_last) ? 4'd0 : d_cnt + 4'd1;
							if (d_cnt == div_last) begin
								cal_cnt <= cal_cnt + 13'd1;
								if (cal_cnt == CAL_LAST) begin
									cal_state <= ST_IDLE;
									cal_done <= 1'b1;
									cal_sync_hold <= 1'b0;
								end
							end
						end
					end
				end
				default: begin
					cal_state <= ST_IDLE;
					cal_sync_hold <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Source select and prescaler
	// ----------------------------------------
	wire [1:0] src = active[`VCD_ID_SRC][1:0];
	wire src_bad = (src == 2'b11);
	wire src_pre = ~src[0];
	wire pre_in_level = src[1] ? osc_sync[2] : ext_sync[2];
	wire pre_in_rise = src[1] ? osc_rise : ext_rise;
	wire pre_level;
	wire pre_rise;
	wire pre_fall;

	vcd_prescale u_pre (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.ratio(active[`VCD_ID_PRESCALE][2:0]),
		.in_rise(pre_in_rise),
		.out_level(pre_level),
		.out_rise(pre_rise),
		.out_fall(pre_fall)
	);

	wire dist_level = src_pre ? pre_level : ext_sync[2];
	wire dist_rise = src_pre ? pre_rise : ext_rise;
	wire dist_fall = src_pre ? pre_fall : ext_fall;
	wire hold = cal_sync_hold | src_bad;

	// ----------------------------------------
	// Channel dividers
	// ----------------------------------------
	wire [4:0] first_level;
	wire [4:0] first_rise;
	wire [4:0] first_fall;
	wire [1:0] second_level;

	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_ch
			wire [31:0] cfg = active[`VCD_ID_CH0 + g];
			vcd_chdiv u_div1 (
				.aclk(aclk),
				.aresetn(aresetn),
				.clk_en(clk_en),
				.hold(hold),
				.in_level(dist_level),
				.in_rise(dist_rise),
				.in_fall(dist_fall),
				.high_cnt(cfg[`VCD_CH_HIGH_LSB+3:`VCD_CH_HIGH_LSB]),
				.low_cnt(cfg[`VCD_CH_LOW_LSB+3:`VCD_CH_LOW_LSB]),
				.bypass(cfg[`VCD_CH_BYPASS_BIT]),
				.duty_fix_disable(cfg[`VCD_CH_DUTY_OFF_BIT]),
				.delay(cfg[`VCD_CH_DELAY_LSB+4:`VCD_CH_DELAY_LSB]),
				.start_high(cfg[`VCD_CH_START_BIT]),
				.out_level(first_level[g]),
				.out_rise(first_rise[g]),
				.out_fall(first_fall[g])
			);
			if (g >= 3) begin : g_dual
				// Second stage runs off the first stage's edges, so ratios multiply
				vcd_chdiv u_div2 (
					.aclk(aclk),
					.aresetn(aresetn),
					.clk_en(clk_en),
					.hold(hold),
					.in_level(first_level[g]),
					.in_rise(first_rise[g]),
					.in_fall(first_fall[g]),
					.high_cnt(cfg[`VCD_CH_HIGH2_LSB+3:`VCD_CH_HIGH2_LSB]),
					.low_cnt(cfg[`VCD_CH_LOW2_LSB+3:`VCD_CH_LOW2_LSB]),
					.bypass(cfg[`VCD_CH_BYPASS2_BIT]),
					.duty_fix_disable(cfg[`VCD_CH_DUTY_OFF_BIT]),
					.delay(5'd0),
					.start_high(cfg[`VCD_CH_START_BIT]),
					.out_level(second_level[g-3]),
					.out_rise(),
					.out_fall()
				);
			end
		end
	endgenerate

	// ----------------------------------------
	// Output stage
	// ----------------------------------------
	// Direct routing honoured only when the prescaled path feeds distribution
	wire [2:0] direct_en;
	assign direct_en[0] = active[`VCD_ID_CH0][`VCD_CH_DIRECT_BIT] & src_pre & ~src_bad;
	assign direct_en[1] = active[`VCD_ID_CH0 + 1][`VCD_CH_DIRECT_BIT] & src_pre & ~src_bad;
	assign direct_en[2] = active[`VCD_ID_CH0 + 2][`VCD_CH_DIRECT_BIT] & src_pre & ~src_bad;

	always @(posedge aclk) begin
		if (!aresetn) begin
			ch0_out <= 1'b0;
			ch1_out <= 1'b0;
			ch2_out <= 1'b0;
			ch3_out <= 1'b0;
			ch4_out <= 1'b0;
		end else if (clk_en) begin
			ch0_out <= direct_en[0] ? (pre_in_level & ~hold) : first_level[0];
			ch1_out <= direct_en[1] ? (pre_in_level & ~hold) : first_level[1];
			ch2_out <= direct_en[2] ? (pre_in_level & ~hold) : first_level[2];
			ch3_out <= second_level[0];
			ch4_out <= second_level[1];
		end
	end
endmodule // vcd_top

// File: vcd_clk_src.sv
module vcd_clk_src #(
	parameter REF_HALF = 100, // Reference half period, ns
	parameter EXT_HALF = 75, // External clock half period, ns
	parameter OSC_HALF = 50 // Oscillator half period, ns
) (
	output logic ref_clk = 0, // Reference clock pin
	output logic ext_clk = 0, // External clock pin
	output logic osc_clk = 0 // Oscillator clock
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Free-running sources
	// ----------------------------------------
	// Offset of 7 ns keeps every edge clear of aclk edges, so counts are exact
	initial begin
		#7;
		forever #(REF_HALF) ref_clk = ~ref_clk;
	end
	initial begin
		#7;
		forever #(EXT_HALF) ext_clk = ~ext_clk;
	end
	initial begin
		#7;
		forever #(OSC_HALF) osc_clk = ~osc_clk;
	end
endmodule // vcd_clk_src

// File: vcd_checker.sv
`include "vcd_consts.vh"

module vcd_checker #(
	parameter CAL_CLOCKS = 4400 // Calibration length in calibration clocks
) (
	input wire aclk, // System clock
	input wire aresetn, // Reset, active low
	input wire [11:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	input wire s_axi_awready, // Write address ready
	input wire [1:0] s_axi_bresp, // Write response
	input wire s_axi_bvalid, // Write response valid
	input wire [11:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	input wire s_axi_arready, // Read address ready
	input wire [31:0] s_axi_rdata, // Read data
	input wire s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire ch0_out, // Channel 0
	input wire ch1_out, // Channel 1
	input wire ch2_out, // Channel 2
	input wire ch3_out, // Channel 3
	input wire ch4_out, // Channel 4
	input wire cal_sync_hold // Calibration hold
);
	reg [3:0] since_upd;
	reg stat_rd;
	reg [15:0] run_len;
	wire [4:0] chs = {ch4_out, ch3_out, ch2_out, ch1_out, ch0_out};
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			since_upd <= 4'hf;
			stat_rd <= 1'b0;
			run_len <= 16'h0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				since_upd <= (s_axi_awaddr == {`VCD_IDX_UPDATE, 2'b00}) ? 4'h0 : 4'hf;
			else if (since_upd != 4'hf)
				since_upd <= since_upd + 4'h1;
			if (s_axi_arvalid && s_axi_arready)
				stat_rd <= (s_axi_araddr == {`VCD_IDX_STATUS, 2'b00});
			run_len <= cal_sync_hold ? run_len + 16'h0001 : 16'h0000;
		end
	end
	property p_hold_static;
		cal_sync_hold [*6] ##1 cal_sync_hold |-> $stable(chs);
	endproperty
	a_hold_static: assert property (p_hold_static) else $error("outputs moved in hold");
	property p_upd_cause;
		$rose(cal_sync_hold) |-> since_upd < 4'hc;
	endproperty
	a_upd_cause: assert property (p_upd_cause) else $error("hold without update");
	// Reference is slower than aclk/2, so each edge is at least two cycles
	property p_cal_len;
		$fell(cal_sync_hold) |-> run_len >= 4 * CAL_CLOCKS;
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration too short");
	property p_stat_clear;
		s_axi_rvalid && stat_rd && $past(cal_sync_hold, 2) && cal_sync_hold |-> !s_axi_rdata[6];
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("done set while running");
	property p_aw_pulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("awready not a pulse");
	property p_b_answer;
		s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("no write response");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("no read data");
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data dropped");
	c_cal_start: cover property ($rose(cal_sync_hold));
	c_cal_end: cover property ($fell(cal_sync_hold));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `VCD_RESP_SLVERR);
endmodule // vcd_checker

bind vcd_top vcd_checker #(.CAL_CLOCKS(CAL_CLOCKS)) vcd_checker_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .ch0_out(ch0_out), .ch1_out(ch1_out), .ch2_out(ch2_out),
	.ch3_out(ch3_out), .ch4_out(ch4_out), .cal_sync_hold(cal_sync_hold)
);

// File: test_vcd_top.sv
`include "vcd_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end

module test_vcd_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CALN = 4;
	localparam int RP = 8; // Reference period in aclk cycles
	logic aclk = 0;
	logic aresetn = 0;
	logic clk_en = 1;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, d;
	logic [1:0] r;
	wire awr, wrdy, bv, arr, rv, hold, rclk, eclk, oclk;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [4:0] ch;
	int errors = 0, checks = 0, cyc = 0, h, k;
	logic [9:0] ri [7] = '{`VCD_IDX_CAL, `VCD_IDX_SRC, `VCD_IDX_RDIV, `VCD_IDX_PRESCALE,
		`VCD_IDX_CH0, `VCD_IDX_UPDATE, `VCD_IDX_STATUS};
	logic [31:0] re [7] = '{`VCD_RST_CAL, `VCD_RST_SRC, `VCD_RST_RDIV, `VCD_RST_PRESCALE,
		`VCD_RST_CH, 32'h0000_0000, 32'h0000_0000};

	vcd_clk_src vcd_clk_src_inst (.ref_clk(rclk), .ext_clk(eclk), .osc_clk(oclk));
	vcd_top #(.CAL_CLOCKS(CALN)) vcd_top_inst (
		.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.reference_input_clock(rclk), .ext_clock_in(eclk), .osc_clock_in(oclk),
		.ch0_out(ch[0]), .ch1_out(ch[1]), .ch2_out(ch[2]), .ch3_out(ch[3]), .ch4_out(ch[4]),
		.cal_sync_hold(hold)
	);

	initial begin
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;
	initial begin
		repeat (60000) @(posedge aclk);
		tmo;
	end
	// ----------------------------------------
	// Bus and measurement tasks
	// ----------------------------------------
	task automatic axw(input [9:0] i, input [31:0] v, output [1:0] s);
		int n;
		@(posedge aclk);
		awa <= {i, 2'b00};
		wd <= v;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		for (n = 0; n < 50 && !bv; n++) begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wrdy) wv <= 0;
		end
		if (n == 50) tmo;
		s = br;
		bre <= 0;
	endtask
	task automatic axr(input [9:0] i, output [31:0] v, output [1:0] s);
		int n;
		@(posedge aclk);
		ara <= {i, 2'b00};
		arv <= 1;
		rre <= 1;
		for (n = 0; n < 50 && !rv; n++) begin
			@(posedge aclk);
			if (arr) arv <= 0;
		end
		if (n == 50) tmo;
		v = rdat;
		s = rr;
		rre <= 0;
	endtask
	task automatic cfg(input [9:0] i, input [31:0] v);
		axw(i, v, r);
		`CHK(r, `VCD_RESP_OKAY)
		axw(`VCD_IDX_UPDATE, 32'h0000_0001, r);
	endtask
	// First period after a change is discarded; it may be partial
	task automatic meas(input int c, output int hi, output int lo);
		int n;
		repeat (2) begin
			hi = 0;
			lo = 0;
			for (n = 0; n < 3000 && ch[c] !== 0; n++) @(posedge aclk);
			for (n = 0; n < 3000 && ch[c] !== 1; n++) @(posedge aclk);
			for (; hi < 3000 && ch[c] === 1; hi++) @(posedge aclk);
			for (; lo < 3000 && ch[c] === 0; lo++) @(posedge aclk);
			if (n == 3000 || hi + lo >= 3000) tmo;
		end
	endtask
	task automatic dt(input [1:0] s, input [2:0] p, input int c, input [31:0] v,
		input int eh, input int ep);
		int hi, lo;
		cfg(`VCD_IDX_SRC, s);
		cfg(`VCD_IDX_PRESCALE, p);
		cfg(10'(`VCD_IDX_CH0 + c), v);
		meas(c, hi, lo);
		if (eh >= 0) `CHK(hi, eh)
		`CHK(hi + lo, ep)
	endtask
	task automatic watch(output int nh, output int nc);
		logic [4:0] c0;
		c0 = ch;
		nh = 0;
		nc = 0;
		repeat (60) begin
			@(posedge aclk);
			nh += (hold === 1);
			nc += (ch !== c0);
		end
	endtask
	task automatic calrun(input int e, input logic sl);
		int n, t0;
		for (n = 0; n < 40 && hold !== 1; n++) @(posedge aclk);
		if (n == 40) tmo;
		t0 = cyc;
		axr(`VCD_IDX_STATUS, d, r);
		`CHK(d[6], 1'b0)
		`CHK(ch[0], sl)
		for (n = 0; n < 3000 && hold !== 0; n++) @(posedge aclk);
		if (n == 3000) tmo;
		`CHK(cyc - t0 >= e - 12 && cyc - t0 <= e + 12, 1'b1)
		axr(`VCD_IDX_STATUS, d, r);
		`CHK(d[6], 1'b1)
	endtask
	task tmo;
		errors++;
		tally_and_finish;
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		foreach (ri[j]) begin
			axr(ri[j], d, r);
			`CHK(d, re[j])
		end
		axr(10'h3ff, d, r);
		`CHK(r, `VCD_RESP_SLVERR)
		axw(10'h3ff, 32'h0000_0001, r);
		`CHK(r, `VCD_RESP_SLVERR)
		axw(`VCD_IDX_STATUS, 32'h0000_00ff, r);
		axr(`VCD_IDX_STATUS, d, r);
		`CHK(d, 32'h0000_0000)
		$display("test registers done");
		dt(2'b01, 3'd2, 0, 32'h0000_0221, 12, 30);
		dt(2'b01, 3'd2, 0, 32'h0000_0021, 15, 30);
		dt(2'b01, 3'd2, 0, 32'h0000_0100, 3, 6);
		for (int c = 1; c <= 4; c++) dt(2'b01, 3'd2, c, 32'h1000_0100, 3, 6);
		dt(2'b01, 3'd2, 3, 32'h0110_0000, 24, 48);
		dt(2'b00, 3'd2, 0, 32'h2000_0000, 3, 6);
		dt(2'b10, 3'd2, 0, 32'h0000_0100, 4, 8);
		for (int p = 2; p <= 6; p++) dt(2'b00, p[2:0], 0, 32'h0000_0100, -1, 6 * p);
		cfg(`VCD_IDX_SRC, 32'h0000_0003);
		repeat (8) @(posedge aclk);
		watch(h, k);
		`CHK(k, 0)
		cfg(`VCD_IDX_SRC, 32'h0000_0001);
		$display("test distribution done");
		axw(`VCD_IDX_CAL, 32'h0000_0001, r);
		watch(h, k);
		`CHK(h, 0)
		axw(`VCD_IDX_UPDATE, 32'h0000_0001, r);
		calrun(CALN * 1 * 2 * RP, 1'b0);
		cfg(`VCD_IDX_RDIV, 32'h0000_0002);
		watch(h, k);
		`CHK(h, 0)
		cfg(`VCD_IDX_CH0, 32'h0000_8100);
		cfg(`VCD_IDX_CAL, 32'h0000_0000);
		cfg(`VCD_IDX_CAL, 32'h0000_0003);
		calrun(CALN * 2 * 4 * RP, 1'b1);
		$display("test calibration done");
		tally_and_finish;
	end
endmodule // test_vcd_top
